/* hw/spa_pkg.sv */
// Shared constants, register map and types of the sum-of-products array.
package spa_pkg;
   // ---------------------------------------------------------------
   // Array geometry
   // ---------------------------------------------------------------
   localparam int SPA_NUM_IN = 12;
   localparam int SPA_NUM_CELL = 10;
   localparam int SPA_PT_MIN = 8;
   localparam int SPA_PT_MAX = 16;
   localparam int SPA_PT_STEP = 2;
   localparam int SPA_SIG_N = SPA_NUM_IN + SPA_NUM_CELL;
   localparam int SPA_LIT_W = 2 * SPA_SIG_N;
   localparam int SPA_HI_W = SPA_LIT_W - 32;
   localparam int SPA_PT_OUT = 120;
   localparam int SPA_PT_SRST = SPA_PT_OUT;
   localparam int SPA_PT_ARST = SPA_PT_OUT + 1;
   localparam int SPA_PT_TOTAL = SPA_PT_OUT + 2;
   localparam int SPA_IDX_W = 7;
   localparam int SPA_SIG_W = 64;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SPA_CLK_NS = 20;
   localparam int SPA_IDLE_NS = 320;
   localparam int SPA_IDLE_CYCLES = (SPA_IDLE_NS + SPA_CLK_NS - 1) / SPA_CLK_NS;

   // ---------------------------------------------------------------
   // Register offsets, fields and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] SPA_OFF_CTRL = 8'h00;
   localparam logic [7:0] SPA_OFF_PT_INDEX = 8'h04;
   localparam logic [7:0] SPA_OFF_PT_LO = 8'h08;
   localparam logic [7:0] SPA_OFF_PT_HI = 8'h0c;
   localparam logic [7:0] SPA_OFF_MODE = 8'h10;
   localparam logic [7:0] SPA_OFF_OE = 8'h14;
   localparam logic [7:0] SPA_OFF_PRELOAD = 8'h18;
   localparam logic [7:0] SPA_OFF_STATUS = 8'h1c;
   localparam logic [7:0] SPA_OFF_SIG_LO = 8'h20;
   localparam logic [7:0] SPA_OFF_SIG_HI = 8'h24;
   localparam int SPA_CTRL_SECURE_BIT = 0;
   localparam int SPA_MODE_REG_POS = 0;
   localparam int SPA_MODE_POL_POS = 10;
   localparam int SPA_STAT_IDLE_BIT = 0;
   localparam int SPA_STAT_SECURE_BIT = 1;
   localparam logic [SPA_LIT_W-1:0] SPA_PT_RESET = 44'hfff_ffff_ffff;
   localparam logic [19:0] SPA_MODE_RESET = 20'h00000;
   localparam logic [9:0] SPA_OE_RESET = 10'h000;
   localparam logic [SPA_SIG_W-1:0] SPA_SIG_RESET = 64'h0000_0000_0000_0000;

   // Per-cell configuration carried as one bundle.
   typedef struct packed {
      logic registered;
      logic active_low;
      logic oe;
   } spa_cell_cfg_type;

   // Terms per cell grow towards the middle and shrink again.
   function automatic int spa_pt_count(input int m);
      return (m < SPA_NUM_CELL / 2) ? SPA_PT_MIN + SPA_PT_STEP * m
                                    : SPA_PT_MIN + SPA_PT_STEP * (SPA_NUM_CELL - 1 - m);
   endfunction : spa_pt_count

   // First term index of a cell in the flat term store.
   function automatic int spa_pt_base(input int m);
      int s;
      s = 0;
      for (int k = 0; k < m; k++) begin
         s = s + spa_pt_count(k);
      end
      return s;
   endfunction : spa_pt_base
endpackage : spa_pkg

/* hw/spa_macrocell.sv */
// One output macrocell: term sum, state register and output polarity.
`timescale 1ns/1ns
`default_nettype none
module spa_macrocell
   import spa_pkg::*;
#(
   parameter int NUM_PT = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [NUM_PT-1:0] terms,
   input wire spa_cell_cfg_type cfg,
   input wire logic clk_rise,
   input wire logic sync_clr,
   input wire logic async_clr,
   input wire logic preload_en,
   input wire logic preload_val,
   output logic sop,
   output logic q,
   output logic pin_val
);
   logic next_q;

   // ---------------------------------------------------------------
   // Sum of products
   // ---------------------------------------------------------------
   assign sop = |terms;

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // The asynchronous term wins over everything; the synchronous one
   // waits for a rising array clock, and preload beats a capture.
   assign next_q = async_clr ? 1'b0 :
                   (clk_rise && sync_clr) ? 1'b0 :
                   preload_en ? preload_val :
                   clk_rise ? sop :
                   q;

   // Power-up leaves every cell register low.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   // Output mode: registered or direct, then optional inversion.
   assign pin_val = cfg.active_low ^ (cfg.registered ? q : sop);
endmodule : spa_macrocell
`default_nettype wire

/* hw/spa_array.sv */
// Top of the sum-of-products macrocell array with its APB register file.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module spa_array
   import spa_pkg::*;
#(
   parameter int IDLE_CYCLES = SPA_IDLE_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic arr_clk,
   input wire logic [SPA_NUM_IN-1:0] in_pin,
   input wire logic [SPA_NUM_IN-1:0] in_drive,
   input wire logic [SPA_NUM_CELL-1:0] io_in,
   input wire logic [SPA_NUM_CELL-1:0] io_ext_drive,
   output logic [SPA_NUM_CELL-1:0] io_out,
   output logic [SPA_NUM_CELL-1:0] io_oe,
   output logic low_power
);
   localparam int CW = $clog2(IDLE_CYCLES + 1);

   logic [SPA_NUM_IN-1:0] in_level;
   logic [SPA_NUM_IN-1:0] in_prev;
   logic [SPA_NUM_CELL-1:0] io_level;
   logic [SPA_NUM_CELL-1:0] io_prev;
   logic [SPA_NUM_CELL-1:0] next_io_level;
   logic arr_clk_prev;
   logic [SPA_NUM_CELL-1:0] q;
   logic [SPA_NUM_CELL-1:0] sop;
   logic [SPA_NUM_CELL-1:0] pin_val;
   logic [SPA_NUM_CELL-1:0] fb;
   logic [SPA_LIT_W-1:0] pt_mask [SPA_PT_TOTAL];
   logic [SPA_PT_TOTAL-1:0] pt_val;
   logic [SPA_LIT_W-1:0] lits;
   logic [19:0] mode;
   logic [SPA_NUM_CELL-1:0] oe_ctrl;
   logic [SPA_SIG_W-1:0] signature;
   logic secure;
   logic [SPA_IDX_W-1:0] pt_index;
   logic [CW-1:0] idle_cnt;
   logic [CW-1:0] next_idle_cnt;
   logic pt_written;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic acc;
   logic first;
   logic commit;
   logic wr;
   logic hit_ctrl, hit_idx, hit_lo, hit_hi, hit_mode, hit_oe;
   logic hit_pre, hit_stat, hit_sig_lo, hit_sig_hi, addr_hit;
   logic idx_ok;
   logic [SPA_LIT_W-1:0] pt_sel;
   logic [SPA_LIT_W-1:0] pt_rd;
   logic [31:0] rd_data;

   // The access phase takes two cycles: data is prepared on the first,
   // and the write lands on the edge where the master sees pready.
   assign acc = psel && penable;
   assign first = acc && !pready;
   assign commit = acc && pready;
   assign wr = commit && pwrite;
   assign hit_ctrl = paddr == SPA_OFF_CTRL;
   assign hit_idx = paddr == SPA_OFF_PT_INDEX;
   assign hit_lo = paddr == SPA_OFF_PT_LO;
   assign hit_hi = paddr == SPA_OFF_PT_HI;
   assign hit_mode = paddr == SPA_OFF_MODE;
   assign hit_oe = paddr == SPA_OFF_OE;
   assign hit_pre = paddr == SPA_OFF_PRELOAD;
   assign hit_stat = paddr == SPA_OFF_STATUS;
   assign hit_sig_lo = paddr == SPA_OFF_SIG_LO;
   assign hit_sig_hi = paddr == SPA_OFF_SIG_HI;
   assign addr_hit = hit_ctrl | hit_idx | hit_lo | hit_hi | hit_mode | hit_oe |
                     hit_pre | hit_stat | hit_sig_lo | hit_sig_hi;
   assign idx_ok = pt_index < SPA_IDX_W'(SPA_PT_TOTAL);

   // A secured array reads its pattern back as all zero.
   assign pt_sel = idx_ok ? pt_mask[pt_index] : '0;
   assign pt_rd = secure ? '0 : pt_sel;

   // Read mux; the signature ignores the fuse entirely.
   assign rd_data = ({32{hit_ctrl}} & (32'(secure) << SPA_CTRL_SECURE_BIT)) |
                    ({32{hit_idx}} & 32'(pt_index)) |
                    ({32{hit_lo}} & pt_rd[31:0]) |
                    ({32{hit_hi}} & 32'(pt_rd[SPA_LIT_W-1:32])) |
                    ({32{hit_mode}} & 32'(mode)) |
                    ({32{hit_oe}} & 32'(oe_ctrl)) |
                    ({32{hit_pre}} & 32'(q)) |
                    ({32{hit_stat}} & ((32'(low_power) << SPA_STAT_IDLE_BIT) |
                                       (32'(secure) << SPA_STAT_SECURE_BIT))) |
                    ({32{hit_sig_lo}} & signature[31:0]) |
                    ({32{hit_sig_hi}} & signature[63:32]);

   // Bus answer flops.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= first;
         pslverr <= first && !addr_hit;
         prdata <= (first && !pwrite) ? rd_data : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic preload_en;
   assign preload_en = wr && hit_pre && !secure;

   // The fuse sets once and only reset clears it; it bites at once.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         secure <= 1'b0;
      end else if (wr && hit_ctrl && pwdata[SPA_CTRL_SECURE_BIT]) begin
         secure <= 1'b1;
      end
   end

   // Plain control words.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pt_index <= '0;
         mode <= SPA_MODE_RESET;
         oe_ctrl <= SPA_OE_RESET;
         signature <= SPA_SIG_RESET;
      end else begin
         if (wr && hit_idx) pt_index <= pwdata[SPA_IDX_W-1:0];
         if (wr && hit_mode) mode <= pwdata[19:0];
         if (wr && hit_oe) oe_ctrl <= pwdata[SPA_NUM_CELL-1:0];
         if (wr && hit_sig_lo) signature[31:0] <= pwdata;
         if (wr && hit_sig_hi) signature[63:32] <= pwdata;
      end
   end

   // Term store: all fuses intact means every term reads false, so the
   // shared clear terms come up inactive.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int t = 0; t < SPA_PT_TOTAL; t++) begin
            pt_mask[t] <= SPA_PT_RESET;
         end
         pt_written <= 1'b0;
      end else if (wr && (hit_lo || hit_hi) && idx_ok) begin
         if (hit_lo) pt_mask[pt_index][31:0] <= pwdata;
         if (hit_hi) pt_mask[pt_index][SPA_LIT_W-1:32] <= pwdata[SPA_HI_W-1:0];
         pt_written <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Pin keepers and edge detection
   // ---------------------------------------------------------------
   // An undriven pin keeps its last level; our own drive wins on I/O.
   assign next_io_level = (io_oe & io_out) | (~io_oe & io_ext_drive & io_in) |
                          (~io_oe & ~io_ext_drive & io_level);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         in_level <= '0;
         io_level <= '0;
         in_prev <= '0;
         io_prev <= '0;
         arr_clk_prev <= 1'b0;
      end else begin
         in_level <= (in_drive & in_pin) | (~in_drive & in_level);
         io_level <= next_io_level;
         in_prev <= in_level;
         io_prev <= io_level;
         arr_clk_prev <= arr_clk;
      end
   end

   logic clk_rise;
   logic input_edge_wakeup_detect;
   logic activity;
   logic hold;
   assign clk_rise = arr_clk && !arr_clk_prev;
   assign input_edge_wakeup_detect = (in_level != in_prev) || (io_level != io_prev) ||
                                     clk_rise;
   // Bus writes also wake, so new settings reach the pins at once.
   assign activity = input_edge_wakeup_detect || wr;
   assign hold = low_power && !activity;
   assign next_idle_cnt = activity ? '0 :
                          (idle_cnt == CW'(IDLE_CYCLES)) ? idle_cnt : CW'(idle_cnt + 1'b1);

   // Quiet-time counter and the low-power flag.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_cnt <= '0;
         low_power <= 1'b0;
      end else begin
         idle_cnt <= next_idle_cnt;
         low_power <= !activity && (idle_cnt >= CW'(IDLE_CYCLES - 1));
      end
   end

   // ---------------------------------------------------------------
   // Logic array
   // ---------------------------------------------------------------
   // Registered cells feed back their register, direct ones their pin.
   assign fb = (mode[SPA_MODE_REG_POS +: SPA_NUM_CELL] & q) |
               (~mode[SPA_MODE_REG_POS +: SPA_NUM_CELL] & io_level);
   assign lits = {~{fb, in_level}, {fb, in_level}};

   // A term is the AND of every connected literal.
   for (genvar t = 0; t < SPA_PT_TOTAL; t++) begin : g_term
      assign pt_val[t] = &(~pt_mask[t] | lits);
   end

   logic sync_clr;
   logic async_clr;
   assign sync_clr = pt_val[SPA_PT_SRST];
   assign async_clr = pt_val[SPA_PT_ARST];

   // Ten cells, each taking its own slice of the term store.
   for (genvar m = 0; m < SPA_NUM_CELL; m++) begin : g_cell
      localparam int NPT = spa_pt_count(m);
      localparam int BASE = spa_pt_base(m);
      spa_cell_cfg_type cfg;
      assign cfg = '{registered: mode[SPA_MODE_REG_POS + m],
                     active_low: mode[SPA_MODE_POL_POS + m],
                     oe: oe_ctrl[m]};
      spa_macrocell #(.NUM_PT(NPT)) u_cell (
         .core_clk(core_clk),
         .arst_n(arst_n),
         .terms(pt_val[BASE +: NPT]),
         .cfg(cfg),
         .clk_rise(clk_rise),
         .sync_clr(sync_clr),
         .async_clr(async_clr),
         .preload_en(preload_en),
         .preload_val(pwdata[m]),
         .sop(sop[m]),
         .q(q[m]),
         .pin_val(pin_val[m])
      );
   end

   // Pin drivers; while idle the pins keep their last value.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         io_out <= '0;
         io_oe <= '0;
      end else begin
         if (!hold) io_out <= pin_val;
         io_oe <= oe_ctrl;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   secure_read_block_a: assert property (
      first && !pwrite && (hit_lo || hit_hi) && secure |=> prdata == 32'h0000_0000)
      else $error("term pattern visible while secured");
   sig_read_open_a: assert property (
      first && !pwrite && hit_sig_hi |=> prdata == $past(signature[63:32]))
      else $error("signature read wrong");
   preload_blocked_a: assert property (
      wr && hit_pre && secure && !async_clr && !clk_rise |=> q == $past(q))
      else $error("preload took effect while secured");
   preload_loads_a: assert property (
      wr && hit_pre && !secure && !async_clr && !(clk_rise && sync_clr)
      |=> q == $past(pwdata[SPA_NUM_CELL-1:0]))
      else $error("preload value not loaded");
   async_clear_a: assert property (
      async_clr |=> q == '0)
      else $error("asynchronous clear missed");
   sync_clear_a: assert property (
      sync_clr && !async_clr && !clk_rise |=> q == $past(q) || $past(preload_en))
      else $error("synchronous clear acted without clock edge");
   clock_capture_a: assert property (
      clk_rise && !async_clr && !sync_clr && !preload_en |=> q == $past(sop))
      else $error("register missed its capture");
   clear_idle_reset_a: assert property (
      !pt_written |-> !sync_clr && !async_clr)
      else $error("shared clear term active after power-up");
   wake_on_edge_a: assert property (
      activity |=> !low_power ##1 !low_power)
      else $error("array stayed idle after an edge");
   idle_pins_hold_a: assert property (
      low_power && !activity |=> $stable(io_out))
      else $error("pins moved while idle");
   keeper_hold_a: assert property (
      in_drive == '0 |=> in_level == $past(in_level))
      else $error("undriven input lost its level");

   preload_cov_c: cover property (preload_en ##1 q != '0);
   idle_entry_c: cover property (!low_power ##1 low_power);
   async_clear_c: cover property (q != '0 ##1 async_clr ##1 q == '0);
   secured_read_c: cover property (secure && first && !pwrite && hit_lo);
endmodule : spa_array
`default_nettype wire

/* testbench/spa_board_model.sv */
// Board model that drives the array's dedicated inputs and shares its I/O wires.
`timescale 1ns/1ns
`default_nettype none
module spa_board_model
   import spa_pkg::*;
(
   input wire logic core_clk,
   input wire logic [SPA_NUM_IN-1:0] in_val,
   input wire logic [SPA_NUM_IN-1:0] in_en,
   input wire logic [SPA_NUM_CELL-1:0] io_val,
   input wire logic [SPA_NUM_CELL-1:0] io_en,
   input wire logic [SPA_NUM_CELL-1:0] io_out,
   input wire logic [SPA_NUM_CELL-1:0] io_oe,
   output logic [SPA_NUM_IN-1:0] in_pin,
   output logic [SPA_NUM_IN-1:0] in_drive,
   output logic [SPA_NUM_CELL-1:0] io_in,
   output logic [SPA_NUM_CELL-1:0] io_ext_drive
);
   // ---------------------------------------------------------------
   // Wire levels
   // ---------------------------------------------------------------
   logic [SPA_NUM_IN-1:0] in_last;
   logic [SPA_NUM_CELL-1:0] io_last;
   logic [SPA_NUM_CELL-1:0] io_any;

   // A released line shows the inverse of its last driven level, so only the keeper holds it.
   assign in_pin = (in_en & in_val) | (~in_en & ~in_last);
   assign in_drive = in_en;
   assign io_any = io_oe | io_en;
   assign io_ext_drive = io_en & ~io_oe; // The board backs off while the array drives.
   assign io_in = (io_oe & io_out) | (~io_oe & io_en & io_val) | (~io_any & ~io_last);

   // Remember the last driven level of every line.
   always_ff @(posedge core_clk) begin
      in_last <= (in_en & in_val) | (~in_en & in_last);
      io_last <= (io_any & io_in) | (~io_any & io_last);
   end
endmodule : spa_board_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking testbench of the sum-of-products array over APB and its pins.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top
   import spa_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   localparam int IDLE = 4;
   localparam int LAST_ROW [SPA_NUM_CELL] = '{7, 17, 29, 43, 59, 75, 89, 101, 111, 119};
   logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, arr_clk, low_power;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic last_err;
   logic [SPA_NUM_IN-1:0] in_val, in_en, in_pin, in_drive;
   logic [SPA_NUM_CELL-1:0] io_val, io_en, io_in, io_ext_drive, io_out, io_oe;
   int miscompares, check_count;

   spa_array #(.IDLE_CYCLES(IDLE)) DUT (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .arr_clk(arr_clk), .in_pin(in_pin),
      .in_drive(in_drive), .io_in(io_in), .io_ext_drive(io_ext_drive), .io_out(io_out),
      .io_oe(io_oe), .low_power(low_power));
   spa_board_model board (.core_clk(core_clk), .in_val(in_val), .in_en(in_en),
      .io_val(io_val), .io_en(io_en), .io_out(io_out), .io_oe(io_oe), .in_pin(in_pin),
      .in_drive(in_drive), .io_in(io_in), .io_ext_drive(io_ext_drive));

   // Free-running 50 MHz clock.
   always #10 core_clk = ~core_clk;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   // One APB transfer; the request stands until pready is sampled high.
   // An idle edge follows each transfer, so that no call lowers and raises psel in one step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdata = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
      if (n >= 50) begin
         miscompares++;
         finish_test();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rdata, exp)
   endtask : rd_chk

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   // Writes one whole 44-bit term row, low half first.
   task automatic row(input int idx, input logic [31:0] lo, input logic [31:0] hi);
      wr(SPA_OFF_PT_INDEX, 32'(idx));
      wr(SPA_OFF_PT_LO, lo);
      wr(SPA_OFF_PT_HI, hi);
   endtask : row

   // One array clock pulse, high and low for several core cycles each.
   task automatic pulse();
      arr_clk <= 1'b1;
      cyc(2);
      arr_clk <= 1'b0;
      cyc(4);
   endtask : pulse

   // Main sequence.
   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      {psel, penable, pwrite, arr_clk} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      in_val = '0;
      in_en = '1;
      io_val = '0;
      io_en = '0;
      miscompares = 0;
      check_count = 0;
      cyc(20);
      arst_n <= 1'b1;
      cyc(1);
      rd_chk(SPA_OFF_MODE, 32'h0000_0000);
      rd_chk(SPA_OFF_OE, 32'h0000_0000);
      rd_chk(SPA_OFF_PRELOAD, 32'h0000_0000);
      rd_chk(SPA_OFF_SIG_LO, 32'h0000_0000);
      rd_chk(SPA_OFF_STATUS, 32'h0000_0001);
      rd_chk(8'h28, 32'h0000_0000);
      `CHK(last_err, 1'b1)
      wr(SPA_OFF_SIG_LO, 32'h5a5a_0f0f);
      wr(SPA_OFF_SIG_HI, 32'h1234_abcd);
      rd_chk(SPA_OFF_SIG_LO, 32'h5a5a_0f0f);
      rd_chk(SPA_OFF_SIG_HI, 32'h1234_abcd);
      // The last term row of each cell copies one input, which pins down each cell's term count.
      for (int m = 0; m < SPA_NUM_CELL; m++) begin
         row(LAST_ROW[m], 32'h1 << m, 32'h0000_0000);
      end
      wr(SPA_OFF_OE, 32'h0000_03ff);
      in_val <= 12'h6b3;
      cyc(4);
      `CHK(io_out, 10'h2b3)
      `CHK(io_oe, 10'h3ff)
      in_val <= 12'h94c;
      cyc(4);
      `CHK(io_out, 10'h14c)
      wr(SPA_OFF_MODE, 32'h000f_fc00);
      cyc(4);
      `CHK(io_out, 10'h2b3)
      wr(SPA_OFF_MODE, 32'h0000_03ff);
      cyc(4);
      `CHK(io_out, 10'h000)
      in_val <= 12'h0f0;
      cyc(4);
      `CHK(io_out, 10'h000)
      pulse();
      `CHK(io_out, 10'h0f0)
      wr(SPA_OFF_PRELOAD, 32'h0000_02a5);
      cyc(4);
      `CHK(io_out, 10'h2a5)
      rd_chk(SPA_OFF_PRELOAD, 32'h0000_02a5);
      // A true sync clear term waits for the array clock.
      row(120, 32'h0000_0000, 32'h0000_0000);
      cyc(4);
      `CHK(io_out, 10'h2a5)
      pulse();
      `CHK(io_out, 10'h000)
      row(120, 32'hffff_ffff, 32'h0000_0fff);
      wr(SPA_OFF_PRELOAD, 32'h0000_0155);
      cyc(4);
      `CHK(io_out, 10'h155)
      // A true async clear term acts with no array clock at all.
      row(121, 32'h0000_0000, 32'h0000_0000);
      cyc(3);
      `CHK(io_out, 10'h000)
      row(121, 32'hffff_ffff, 32'h0000_0fff);
      wr(SPA_OFF_PRELOAD, 32'h0000_03c3);
      cyc(4);
      `CHK(io_out, 10'h3c3)
      // Cell 1 now follows the I/O wire of cell 0, which the board drives.
      wr(SPA_OFF_MODE, 32'h0000_0000);
      row(17, 32'h0000_1000, 32'h0000_0000);
      wr(SPA_OFF_OE, 32'h0000_03fe);
      in_val <= 12'h000;
      io_val <= 10'h001;
      io_en <= 10'h001;
      cyc(4);
      `CHK(io_out[1:0], 2'b10)
      io_en <= 10'h000;
      cyc(4);
      `CHK(io_out[1], 1'b1)
      in_en <= '0;
      cyc(4);
      `CHK(io_out[2], 1'b0)
      cyc(IDLE + 2);
      `CHK(low_power, 1'b1)
      in_val <= 12'h004;
      in_en <= '1;
      cyc(3);
      `CHK(low_power, 1'b0)
      cyc(2);
      `CHK(io_out[2], 1'b1)
      // Term readback works until the fuse is set; signature stays open.
      wr(SPA_OFF_PT_INDEX, 32'h0000_0000);
      rd_chk(SPA_OFF_PT_LO, 32'hffff_ffff);
      rd_chk(SPA_OFF_PT_HI, 32'h0000_0fff);
      wr(SPA_OFF_CTRL, 32'h0000_0001);
      rd_chk(SPA_OFF_PT_LO, 32'h0000_0000);
      rd_chk(SPA_OFF_CTRL, 32'h0000_0001);
      wr(SPA_OFF_PRELOAD, 32'h0000_00ff);
      rd_chk(SPA_OFF_PRELOAD, 32'h0000_03c3);
      rd_chk(SPA_OFF_SIG_HI, 32'h1234_abcd);
      rd_chk(SPA_OFF_STATUS, 32'h0000_0003);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
